// ### logic/sbrh_device.sv
`include "sbrh_defines.svh"
`default_nettype none

module sbrh_device
	import sbrh_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        sys_rst,
	sbrh_if.device           link,
	input  wire sbrh_event_t reply_event,
	input  wire logic [6:0]  out_queue_bytes,
	input  wire logic        refusal_clear,
	output var  logic        reply_busy,
	output var  logic        event_dropped,
	output var  logic        intr_refused,
	output var  logic [3:0]  sys_reply_code,
	output var  logic        sys_reply_valid
);
	logic [4:0]      code_reg;
	logic [4:0]      code_next;
	sbrh_state_t     state_reg;
	sbrh_state_t     state_next;
	logic            busy_reg;
	logic            drop_reg;
	logic            refused_reg;
	logic [3:0]      sreply_sync;
	logic [3:0]      sreply_reg;
	logic            svalid_reg;

	// system reply comes from another chip: two flops first
	sbrh_sync #(.WIDTH(4)) u_sync (
		.clock   (clock),
		.sys_rst (sys_rst),
		.din     (link.sys_reply),
		.dout    (sreply_sync)
	);

	// translate request event to a reply code
	logic [4:0] ev_code;
	logic       ev_ready;
	always_comb begin
		ev_code  = `SBRH_P_IDLE;
		ev_ready = 1'b1;
		unique case (reply_event)
			SBRH_EV_NONE:       ev_code = `SBRH_P_IDLE;
			SBRH_EV_BLOCK_WR:   ev_code = `SBRH_P_BLOCK_WR_ACK;
			SBRH_EV_SINGLE_WR:  ev_code = `SBRH_P_SINGLE_WR_ACK;
			SBRH_EV_FATAL:      ev_code = `SBRH_P_FATAL_ERROR;
			SBRH_EV_RD_ERR:     ev_code = `SBRH_P_READ_DATA_ERR;
			SBRH_EV_SINGLE_RD: begin
				ev_code  = `SBRH_P_SINGLE_RD_ACK;
				ev_ready = out_queue_bytes >= `SBRH_SINGLE_BYTES;
			end
			SBRH_EV_BLOCK_RD: begin
				ev_code  = `SBRH_P_BLOCK_RD_ACK;
				ev_ready = out_queue_bytes >= `SBRH_BLOCK_BYTES;
			end
			SBRH_EV_COPYBACK: begin
				ev_code  = `SBRH_P_COH_BLOCK_ACK;
				ev_ready = out_queue_bytes >= `SBRH_BLOCK_BYTES;
			end
			SBRH_EV_COH_SLAVE:  ev_code = `SBRH_P_COH_SLV_ACK;
			SBRH_EV_INTR_DONE:  ev_code = `SBRH_P_INTR_ACK;
			SBRH_EV_INVAL_DONE: ev_code = `SBRH_P_INVAL_ACK;
			SBRH_EV_COH_ERR:    ev_code = `SBRH_P_COH_RD_ERR;
			SBRH_EV_TIMEOUT:    ev_code = `SBRH_P_READ_TIMEOUT;
			SBRH_EV_ABSENT:     ev_code = `SBRH_P_BLOCK_ABSENT;
			default:            ev_code = `SBRH_P_IDLE;
		endcase
	end

	// reserved value cannot be produced; single codes hold one cycle
	wire ev_live   = (reply_event != SBRH_EV_NONE) && ev_ready
		&& (ev_code != `SBRH_P_RESERVED);
	wire ev_two    = ev_code[4] && (ev_code[3:0] >= 4'h5);
	wire can_take  = (state_reg == SBRH_ST_IDLE);
	wire take      = ev_live && can_take;
	wire dropped   = (reply_event != SBRH_EV_NONE) && !take;

	// reply sequencer: idle, optional first cycle, second cycle
	always_comb begin
		state_next = state_reg;
		code_next  = `SBRH_P_IDLE;
		unique case (state_reg)
			SBRH_ST_IDLE: begin
				if (take) begin
					code_next  = ev_code;
					state_next = ev_two ? SBRH_ST_FIRST : SBRH_ST_SECOND;
				end
			end
			SBRH_ST_FIRST: begin
				code_next  = code_reg;
				state_next = SBRH_ST_SECOND;
			end
			SBRH_ST_SECOND: begin
				state_next = SBRH_ST_IDLE;
			end
			default: state_next = SBRH_ST_IDLE;
		endcase
	end

	// idle system reply carries nothing
	wire s_live    = (sreply_sync != `SBRH_S_IDLE);
	wire s_refusal = (sreply_sync == `SBRH_S_INTR_REFUSAL);

	// hold sequencer and reply lines
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_reg <= SBRH_ST_IDLE;
			code_reg  <= `SBRH_P_IDLE;
			busy_reg  <= 1'b0;
			drop_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			code_reg  <= code_next;
			busy_reg  <= (state_next != SBRH_ST_IDLE);
			drop_reg  <= dropped;
		end
	end

	// sticky refusal flag; a new refusal beats a clear in the same cycle
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			refused_reg <= 1'b0;
		end else begin
			refused_reg <= s_refusal || (refused_reg && !refusal_clear);
		end
	end

	// pass decoded system replies to the local buffer control
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			sreply_reg <= `SBRH_S_IDLE;
			svalid_reg <= 1'b0;
		end else begin
			sreply_reg <= sreply_sync;
			svalid_reg <= s_live;
		end
	end

	assign link.proc_reply = code_reg;
	assign reply_busy      = busy_reg;
	assign event_dropped   = drop_reg;
	assign intr_refused    = refused_reg;
	assign sys_reply_code  = sreply_reg;
	assign sys_reply_valid = svalid_reg;
endmodule

`default_nettype wire

// ### logic/sbrh_sync.sv
`include "sbrh_defines.svh"
`default_nettype none

// two-stage synchroniser for a bus of pin inputs
module sbrh_sync #(
	parameter int WIDTH = 4
) (
	input  wire logic             clock,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] din,
	output var  logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_reg;

	// a zero-width bus has nothing to carry
	if (WIDTH < 1) begin : g_bad_width
		$error("sbrh_sync: WIDTH must be positive");
	end

	// first stage is read only by the second
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			meta_reg <= '0;
			dout     <= '0;
		end else begin
			meta_reg <= din;
			dout     <= meta_reg;
		end
	end
endmodule

`default_nettype wire

// ### logic/sbrh_system.sv
`include "sbrh_defines.svh"
`default_nettype none

// system controller end: issues replies, sees processor replies
module sbrh_system
	import sbrh_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       sys_rst,
	sbrh_if.system          link,
	input  wire logic       cmd_valid,
	input  wire logic [3:0] cmd_code,
	output var  logic       cmd_taken,
	output var  logic [4:0] proc_code,
	output var  logic       proc_valid,
	output var  logic       drive_pending
);
	logic [3:0] reply_reg;
	logic       taken_reg;
	logic [4:0] preply_sync;
	logic [4:0] pcode_reg;
	logic       pvalid_reg;
	logic       pend_reg;
	logic [4:0] prev_reg;

	sbrh_sync #(.WIDTH(5)) u_sync (
		.clock   (clock),
		.sys_rst (sys_rst),
		.din     (link.proc_reply),
		.dout    (preply_sync)
	);

	// a two-cycle reply counts once: react on its first cycle
	wire p_new     = (preply_sync != `SBRH_P_IDLE) && (preply_sync != prev_reg);
	wire p_wants   = p_new && ((preply_sync == `SBRH_P_SINGLE_RD_ACK)
		|| (preply_sync == `SBRH_P_BLOCK_RD_ACK)
		|| (preply_sync == `SBRH_P_COH_BLOCK_ACK));
	// drive command matching the ready data
	wire [3:0] drv = (preply_sync == `SBRH_P_SINGLE_RD_ACK) ? `SBRH_S_SINGLE_DRV
		: (preply_sync == `SBRH_P_BLOCK_RD_ACK) ? `SBRH_S_BLOCK_DRV
		: `SBRH_S_COPYBACK_DRV;
	// timeout from a slave is forwarded as system read timeout
	wire fwd_to    = p_new && (preply_sync == `SBRH_P_READ_TIMEOUT);
	wire host_ok   = cmd_valid && !p_wants && !fwd_to;

	// one reply a cycle, idle otherwise; data-ready replies take priority
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			reply_reg <= `SBRH_S_IDLE;
			taken_reg <= 1'b0;
			prev_reg  <= `SBRH_P_IDLE;
			pend_reg  <= 1'b0;
		end else begin
			prev_reg  <= preply_sync;
			taken_reg <= host_ok;
			pend_reg  <= p_wants;
			if (p_wants)
				reply_reg <= drv;
			else if (fwd_to)
				reply_reg <= `SBRH_S_READ_TIMEOUT;
			else if (host_ok)
				reply_reg <= cmd_code;
			else
				reply_reg <= `SBRH_S_IDLE;
		end
	end

	// report processor replies upward
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pcode_reg  <= `SBRH_P_IDLE;
			pvalid_reg <= 1'b0;
		end else begin
			pcode_reg  <= preply_sync;
			pvalid_reg <= p_new;
		end
	end

	assign link.sys_reply = reply_reg;
	assign cmd_taken      = taken_reg;
	assign proc_code      = pcode_reg;
	assign proc_valid     = pvalid_reg;
	assign drive_pending  = pend_reg;
endmodule

`default_nettype wire

// ### shared/sbrh_defines.svh
`ifndef SBRH_DEFINES_SVH
`define SBRH_DEFINES_SVH

// processor reply codes, five lines, class bit on top
`define SBRH_P_W             5
`define SBRH_P_IDLE          5'h00
`define SBRH_P_BLOCK_WR_ACK  5'h11
`define SBRH_P_SINGLE_WR_ACK 5'h12
`define SBRH_P_FATAL_ERROR   5'h04
`define SBRH_P_READ_DATA_ERR 5'h15
`define SBRH_P_RESERVED      5'h16
`define SBRH_P_BLOCK_ABSENT  5'h17
`define SBRH_P_SINGLE_RD_ACK 5'h18
`define SBRH_P_BLOCK_RD_ACK  5'h19
`define SBRH_P_COH_BLOCK_ACK 5'h1a
`define SBRH_P_COH_SLV_ACK   5'h1b
`define SBRH_P_INTR_ACK      5'h1c
`define SBRH_P_INVAL_ACK     5'h1d
`define SBRH_P_COH_RD_ERR    5'h1e
`define SBRH_P_READ_TIMEOUT  5'h1f

// system reply codes, four lines
`define SBRH_S_W             4
`define SBRH_S_IDLE          4'h0
`define SBRH_S_ERROR         4'h1
`define SBRH_S_COPYBACK_DRV  4'h2
`define SBRH_S_WB_CANCEL     4'h3
`define SBRH_S_SINGLE_WR_ACK 4'h4
`define SBRH_S_BLOCK_WR_ACK  4'h5
`define SBRH_S_OWN_GRANT     4'h6
`define SBRH_S_INTR_REFUSAL  4'h7
`define SBRH_S_UNSHARED_ACK  4'h8
`define SBRH_S_SHARED_ACK    4'h9
`define SBRH_S_SINGLE_RD_ACK 4'ha
`define SBRH_S_READ_TIMEOUT  4'hb
`define SBRH_S_SLV_WR_SINGLE 4'hc
`define SBRH_S_SLV_WR_BLOCK  4'hd
`define SBRH_S_SINGLE_DRV    4'he
`define SBRH_S_BLOCK_DRV     4'hf

// byte counts moved by buffer commands
`define SBRH_SINGLE_BYTES    7'd16
`define SBRH_BLOCK_BYTES     7'd64

`endif

// ### shared/sbrh_if.sv
`default_nettype none

// point-to-point reply lines between the processor port and the system
interface sbrh_if;
	logic [4:0] proc_reply;
	logic [3:0] sys_reply;

	modport device (output proc_reply, input sys_reply);
	modport system (input proc_reply, output sys_reply);
endinterface

`default_nettype wire

// ### shared/sbrh_pkg.sv
`default_nettype none

package sbrh_pkg;
	// what the device is answering
	typedef enum logic [3:0] {
		SBRH_EV_NONE       = 4'h0,
		SBRH_EV_BLOCK_WR   = 4'h1,
		SBRH_EV_SINGLE_WR  = 4'h2,
		SBRH_EV_FATAL      = 4'h3,
		SBRH_EV_RD_ERR     = 4'h4,
		SBRH_EV_SINGLE_RD  = 4'h5,
		SBRH_EV_BLOCK_RD   = 4'h6,
		SBRH_EV_COPYBACK   = 4'h7,
		SBRH_EV_COH_SLAVE  = 4'h8,
		SBRH_EV_INTR_DONE  = 4'h9,
		SBRH_EV_INVAL_DONE = 4'ha,
		SBRH_EV_COH_ERR    = 4'hb,
		SBRH_EV_TIMEOUT    = 4'hc,
		SBRH_EV_ABSENT     = 4'hd
	} sbrh_event_t;

	// one-hot states of the reply driver
	typedef enum logic [2:0] {
		SBRH_ST_IDLE   = 3'b001,
		SBRH_ST_FIRST  = 3'b010,
		SBRH_ST_SECOND = 3'b100
	} sbrh_state_t;
endpackage

`default_nettype wire

// ### sim/sbrh_sva.sv
`default_nettype none

// watches both reply channels from beside the link
module sbrh_sva (
	input wire logic       clock,
	input wire logic       sys_rst,
	input wire logic [4:0] proc_reply,
	input wire logic [3:0] sys_reply
);
	timeunit 1ns;
	timeprecision 1ns;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	// a new processor reply must bring its buffer command three cycles on
	property p_fwd(logic [4:0] p, logic [3:0] s);
		(proc_reply == p && $past(proc_reply) != p) |-> ##3 sys_reply == s;
	endproperty

	a_no_reserved: assert property (proc_reply != 5'h16)
		else $error("reserved reply code driven");
	a_write_ack_one: assert property (
		(proc_reply inside {5'h11, 5'h12}) |=> proc_reply == 5'h00)
		else $error("write ack held too long");
	a_fatal_one: assert property (proc_reply == 5'h04 |=> proc_reply == 5'h00)
		else $error("fatal reply held too long");
	a_two_hold: assert property ((proc_reply[4] && proc_reply[3:0] >= 4'h5
		&& proc_reply != $past(proc_reply)) |=> $stable(proc_reply) ##1 proc_reply == 5'h00)
		else $error("two cycle reply length wrong");
	a_class_bit: assert property (
		proc_reply != 5'h00 |-> proc_reply[4] || proc_reply == 5'h04)
		else $error("reply without class bit");
	a_single_drive: assert property (p_fwd(5'h18, 4'he))
		else $error("single drive missing");
	a_block_drive: assert property (p_fwd(5'h19, 4'hf))
		else $error("block drive missing");
	a_copyback_drive: assert property (p_fwd(5'h1a, 4'h2))
		else $error("copyback drive missing");
	a_timeout_fwd: assert property (p_fwd(5'h1f, 4'hb))
		else $error("timeout not forwarded");

	c_single_rd: cover property (proc_reply == 5'h18);
	c_copyback: cover property (sys_reply == 4'h2);
	c_refusal: cover property (sys_reply == 4'h7);
endmodule

`default_nettype wire

// ### sim/tb_top.sv
`default_nettype none

module tb_top
	import sbrh_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	typedef struct {sbrh_event_t ev; logic [6:0] q; logic [4:0] code; int n;} sbrh_row_t;

	logic        clock, sys_rst, refusal_clear, cmd_valid, reply_busy, event_dropped;
	logic        intr_refused, sys_reply_valid, cmd_taken, proc_valid, drive_pending;
	sbrh_event_t reply_event;
	logic [6:0]  out_queue_bytes;
	logic [3:0]  cmd_code, sys_reply_code;
	logic [4:0]  proc_code, last_code;
	int          err_total, checked;
	int          drives = 0;
	// one row per reply kind: event, queued bytes, code, cycles held
	sbrh_row_t   rows[13] = '{'{SBRH_EV_BLOCK_WR, 7'h00, 5'h11, 1},
		'{SBRH_EV_SINGLE_WR, 7'h00, 5'h12, 1}, '{SBRH_EV_FATAL, 7'h00, 5'h04, 1},
		'{SBRH_EV_RD_ERR, 7'h00, 5'h15, 2}, '{SBRH_EV_SINGLE_RD, 7'h10, 5'h18, 2},
		'{SBRH_EV_BLOCK_RD, 7'h40, 5'h19, 2}, '{SBRH_EV_COPYBACK, 7'h40, 5'h1a, 2},
		'{SBRH_EV_COH_SLAVE, 7'h00, 5'h1b, 2}, '{SBRH_EV_INTR_DONE, 7'h00, 5'h1c, 2},
		'{SBRH_EV_INVAL_DONE, 7'h00, 5'h1d, 2}, '{SBRH_EV_COH_ERR, 7'h00, 5'h1e, 2},
		'{SBRH_EV_TIMEOUT, 7'h00, 5'h1f, 2}, '{SBRH_EV_ABSENT, 7'h00, 5'h17, 2}};

	sbrh_if link();
	sbrh_device u_sbrh_device (.clock(clock), .sys_rst(sys_rst), .link(link),
		.reply_event(reply_event), .out_queue_bytes(out_queue_bytes),
		.refusal_clear(refusal_clear), .reply_busy(reply_busy),
		.event_dropped(event_dropped), .intr_refused(intr_refused),
		.sys_reply_code(sys_reply_code), .sys_reply_valid(sys_reply_valid));
	sbrh_system u_sbrh_system (.clock(clock), .sys_rst(sys_rst), .link(link),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_taken(cmd_taken),
		.proc_code(proc_code), .proc_valid(proc_valid), .drive_pending(drive_pending));
	sbrh_sva u_sbrh_sva (.clock(clock), .sys_rst(sys_rst), .proc_reply(link.proc_reply),
		.sys_reply(link.sys_reply));

	// 10 MHz clock
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	// keep what the system end last saw from the processor
	always @(posedge clock) begin
		if (proc_valid === 1'b1) last_code <= proc_code;
	end

	// count drive commands that the system end raises
	always @(posedge clock) begin
		if (drive_pending === 1'b1) drives <= drives + 1;
	end

	task automatic chk(input logic [4:0] got, input logic [4:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	// event held one cycle only, so a refusal cannot be retried by accident
	task automatic run_ev(input sbrh_event_t ev, input logic [6:0] q, input logic [4:0] c, int n);
		@(posedge clock);
		reply_event <= ev;
		out_queue_bytes <= q;
		@(posedge clock);
		reply_event <= SBRH_EV_NONE;
		for (int i = 0; i < n; i++) begin
			#1 chk(link.proc_reply, c);
			chk({4'h0, reply_busy}, 5'h01);
			@(posedge clock);
		end
		#1 chk(link.proc_reply, 5'h00);
		chk({4'h0, reply_busy}, 5'h00);
	endtask

	task automatic sys_cmd(input logic [3:0] c);
		int k;
		@(posedge clock);
		cmd_valid <= 1'b1;
		cmd_code <= c;
		@(posedge clock);
		cmd_valid <= 1'b0;
		#1 chk({4'h0, cmd_taken}, 5'h01);
		k = 0;
		while (sys_reply_valid !== 1'b1 && k < 8) begin
			@(posedge clock);
			#1 k++;
		end
		chk({4'h0, sys_reply_valid}, 5'h01);
		chk({1'b0, sys_reply_code}, {1'b0, c});
	endtask

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// stalls are cut short long before the sequence could need this much
	initial begin
		repeat (5000) @(posedge clock);
		err_total++;
		summarize();
	end

	initial begin
		sys_rst = 1'b1;
		reply_event = SBRH_EV_NONE;
		out_queue_bytes = 7'h00;
		refusal_clear = 1'b0;
		cmd_valid = 1'b0;
		cmd_code = 4'h0;
		repeat (10) @(posedge clock);
		sys_rst <= 1'b0;
		#1 chk(link.proc_reply, 5'h00);
		chk({1'b0, link.sys_reply}, 5'h00);
		foreach (rows[i]) begin
			run_ev(rows[i].ev, rows[i].q, rows[i].code, rows[i].n);
			repeat (3) @(posedge clock);
			#1 chk(last_code, rows[i].code);
		end
		// single read, block read and copyback rows each raise one drive
		chk(drives[4:0], 5'h03);
		// a host reply that meets a drive command loses its slot
		@(posedge clock);
		reply_event <= SBRH_EV_SINGLE_RD;
		out_queue_bytes <= 7'h10;
		@(posedge clock);
		reply_event <= SBRH_EV_NONE;
		repeat (2) @(posedge clock);
		cmd_valid <= 1'b1;
		cmd_code <= 4'h6;
		@(posedge clock);
		cmd_valid <= 1'b0;
		#1 chk({4'h0, cmd_taken}, 5'h00);
		chk({1'b0, link.sys_reply}, 5'h0e);
		chk({4'h0, drive_pending}, 5'h01);
		// data one byte short of the threshold is refused
		run_ev(SBRH_EV_SINGLE_RD, 7'h0f, 5'h00, 0);
		chk({4'h0, event_dropped}, 5'h01);
		run_ev(SBRH_EV_COPYBACK, 7'h3f, 5'h00, 0);
		chk({4'h0, event_dropped}, 5'h01);
		// second event while the first reply still stands
		@(posedge clock);
		reply_event <= SBRH_EV_INTR_DONE;
		@(posedge clock);
		reply_event <= SBRH_EV_INVAL_DONE;
		@(posedge clock);
		reply_event <= SBRH_EV_NONE;
		#1 chk(link.proc_reply, 5'h1c);
		chk({4'h0, event_dropped}, 5'h01);
		for (int c = 1; c < 16; c++) sys_cmd(c[3:0]);
		chk({4'h0, intr_refused}, 5'h01);
		@(posedge clock);
		refusal_clear <= 1'b1;
		@(posedge clock);
		refusal_clear <= 1'b0;
		repeat (2) @(posedge clock);
		#1 chk({4'h0, intr_refused}, 5'h00);
		// a refusal landing in the cycle of a clear still sets the flag
		@(posedge clock);
		cmd_valid <= 1'b1;
		cmd_code <= 4'h7;
		@(posedge clock);
		cmd_valid <= 1'b0;
		repeat (2) @(posedge clock);
		refusal_clear <= 1'b1;
		@(posedge clock);
		refusal_clear <= 1'b0;
		#1 chk({4'h0, intr_refused}, 5'h01);
		// reset in the middle of a two cycle reply
		@(posedge clock);
		reply_event <= SBRH_EV_INTR_DONE;
		@(posedge clock);
		reply_event <= SBRH_EV_NONE;
		sys_rst <= 1'b1;
		@(posedge clock);
		sys_rst <= 1'b0;
		#1 chk(link.proc_reply, 5'h00);
		chk({4'h0, reply_busy}, 5'h00);
		chk({4'h0, intr_refused}, 5'h00);
		repeat (4) @(posedge clock);
		summarize();
	end
endmodule

`default_nettype wire
